/* logic/fhs_defines.vh */
// fhs_defines.vh: offsets, field positions, reset values and timing figures
// for the head seek and id search sequencer; definitions only.
`ifndef FHS_DEFINES_VH
`define FHS_DEFINES_VH

// register byte offsets
`define FHS_OFF_CMD_STAT 8'h00
`define FHS_OFF_TRACK 8'h04
`define FHS_OFF_SECTOR 8'h08
`define FHS_OFF_DATA 8'h0C
`define FHS_OFF_CTRL 8'h10

// command word fields
`define FHS_CMD_RATE_LO 0
`define FHS_CMD_VERIFY 2
`define FHS_CMD_HEAD 3
`define FHS_CMD_UPDATE 4
`define FHS_CMD_SIDE_CMP 1
`define FHS_CMD_SIDE_SEL 1
`define FHS_CMD_E_DELAY 2
`define FHS_CMD_SIDE_EXP 3
`define FHS_CMD_MULTI 4

// control register fields
`define FHS_CTL_DENSITY 0
`define FHS_CTL_TEST_N 1
`define FHS_CTL_HALF_RATE 2
`define FHS_CTL_SIDE_VAR 3
`define FHS_CTRL_RESET 8'h02

// status bits
`define FHS_ST_BUSY 0
`define FHS_ST_INDEX 1
`define FHS_ST_TRACK0 2
`define FHS_ST_CRC_RNF 3
`define FHS_ST_SEEK_ERR 4
`define FHS_ST_HEAD_UP 5

// timing in its own unit, clock rate in MHz
`define FHS_CLK_MHZ 25
`define FHS_PULSE_DD_US 2
`define FHS_PULSE_SD_US 4
`define FHS_DIR_SETUP_US 12
`define FHS_RATE0_US 3000
`define FHS_RATE1_US 6000
`define FHS_RATE2_US 10000
`define FHS_RATE3_US 15000
`define FHS_TRATE0_US 184
`define FHS_TRATE1_US 190
`define FHS_TRATE2_US 198
`define FHS_TRATE3_US 208
`define FHS_SETTLE_US 15000
`define FHS_PULSE_DD_CYC (`FHS_PULSE_DD_US * `FHS_CLK_MHZ)
`define FHS_PULSE_SD_CYC (`FHS_PULSE_SD_US * `FHS_CLK_MHZ)
`define FHS_DIR_SETUP_CYC (`FHS_DIR_SETUP_US * `FHS_CLK_MHZ)

// counts
`define FHS_RESTORE_MAX 8'hFF
`define FHS_VERIFY_REVS 3'h5
`define FHS_SEARCH_REVS 3'h4
`define FHS_SIDE_REVS 3'h5
`define FHS_IDLE_INDEX 4'hF
`define FHS_TRACK_MAX 8'h4C

`endif

/* logic/fhs_seek_search.v */
// fhs_seek_search.v: floppy head positioning and sector id search sequencer
// with an axi4-lite register slave. Assumes drive and id-reader inputs are
// synchronous to clk and id_valid_in is a one-cycle pulse per id field read.
// What this block does
// RQ1: step pulse 2 us double, 4 us single density
// RQ2: direction high inward, kept, valid 12 us early
// RQ3: rate field selects interval; test shortens it
// RQ4: verify settles 15 ms, zero in test
// RQ5: sector command engages head, optional delay, waits
// RQ6: verify: track match, good crc ends cleanly
// RQ7: track match, bad crc sets crc bit
// RQ8: no good id in five revolutions: seek error
// RQ9: head engaged on h, verify end, sector command
// RQ10: head released on h=v=0 or 15 idle indexes
// RQ11: type 1 status bit 5 is engage and engaged
// RQ12: restore steps out until track zero, clears track
// RQ13: restore gives up after 255 steps
// RQ14: seek steps until track equals data register
// RQ15: step repeats last direction, optional update
// RQ16: step-in moves toward track 76, increments
// RQ17: step-out moves toward zero, decrements
// RQ18: positioning leaves side select, no side compare
// RQ19: sector command busy, matches track then sector
// RQ20: four revolutions without match: record missing
// RQ21: multi-sector increments sector until missing or forced
// RQ22: side compare timeout five indexes: record missing
// RQ23: bit 4 gates track register updates on step commands
// RQ24: busy drops with the completion interrupt, except on a force with a zero condition nibble
`include "fhs_defines.vh"
`default_nettype none

module fhs_seek_search #(
    parameter [20:0] RATE0_CYC = `FHS_RATE0_US * `FHS_CLK_MHZ,
    parameter [20:0] RATE1_CYC = `FHS_RATE1_US * `FHS_CLK_MHZ,
    parameter [20:0] RATE2_CYC = `FHS_RATE2_US * `FHS_CLK_MHZ,
    parameter [20:0] RATE3_CYC = `FHS_RATE3_US * `FHS_CLK_MHZ,
    parameter [20:0] TRATE0_CYC = `FHS_TRATE0_US * `FHS_CLK_MHZ,
    parameter [20:0] TRATE1_CYC = `FHS_TRATE1_US * `FHS_CLK_MHZ,
    parameter [20:0] TRATE2_CYC = `FHS_TRATE2_US * `FHS_CLK_MHZ,
    parameter [20:0] TRATE3_CYC = `FHS_TRATE3_US * `FHS_CLK_MHZ,
    parameter [20:0] SETTLE_CYC = `FHS_SETTLE_US * `FHS_CLK_MHZ
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // drive
    output reg step_out,
    output reg direction_out,
    output reg head_engage_out,
    output reg side_select_out,
    input wire head_engaged_in,
    input wire track_zero_in,
    input wire index_in,
    // id field reader and data path
    input wire id_valid_in,
    input wire [7:0] id_track_in,
    input wire id_side_in,
    input wire [7:0] id_sector_in,
    input wire id_crc_ok_in,
    output reg sector_found_out,
    input wire sector_done_in,
    // completion
    output reg command_done_irq,
    output reg busy_out
);

    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_DIR = 4'h1;
    localparam [3:0] S_PULSE = 4'h2;
    localparam [3:0] S_GAP = 4'h3;
    localparam [3:0] S_SETTLE = 4'h4;
    localparam [3:0] S_HEAD = 4'h5;
    localparam [3:0] S_SEARCH = 4'h6;
    localparam [3:0] S_XFER = 4'h7;
    localparam [20:0] PULSE_DD = `FHS_PULSE_DD_CYC;
    localparam [20:0] PULSE_SD = `FHS_PULSE_SD_CYC;
    localparam [20:0] DIR_SETUP = `FHS_DIR_SETUP_CYC;

    reg [3:0] state_reg;
    reg [7:0] cmd_reg, track_reg, sector_reg, data_reg, ctrl_reg;
    reg [20:0] tmr_reg;
    reg [7:0] steps_reg;
    reg [2:0] revs_reg;
    reg [3:0] idle_idx_reg;
    reg index_prev_reg, side_seen_reg, crc_err_reg, seek_err_reg, missing_reg, type1_reg;
    reg aw_have_reg, w_have_reg;
    reg [7:0] awaddr_q_reg, wdata_q_reg;
    reg wstrb_q_reg;

    wire index_edge = index_in & ~index_prev_reg;
    wire test_n = ctrl_reg[`FHS_CTL_TEST_N];
    wire half_rate = ctrl_reg[`FHS_CTL_HALF_RATE];
    wire head_up = head_engage_out & head_engaged_in;
    wire do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire wr_cmd = do_write & wstrb_q_reg & (awaddr_q_reg == `FHS_OFF_CMD_STAT);
    wire is_force = wdata_q_reg[7:4] == 4'hD;
    wire cmd_v = cmd_reg[`FHS_CMD_VERIFY];
    wire cmd_t = cmd_reg[`FHS_CMD_UPDATE];
    wire cmp_side = ctrl_reg[`FHS_CTL_SIDE_VAR] | cmd_reg[`FHS_CMD_SIDE_CMP];
    wire exp_side = ctrl_reg[`FHS_CTL_SIDE_VAR] ? side_select_out : cmd_reg[`FHS_CMD_SIDE_EXP];
    wire side_ok = ~cmp_side | (id_side_in == exp_side);
    wire rd_stat = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `FHS_OFF_CMD_STAT);
    wire map_w = awaddr_q_reg <= `FHS_OFF_CTRL && awaddr_q_reg[1:0] == 2'b00;
    wire map_r = s_axi_araddr <= `FHS_OFF_CTRL && s_axi_araddr[1:0] == 2'b00;

    // 1 MHz operation doubles the step rate and settle intervals
    function [20:0] scale;
        input [20:0] cyc;
        begin
            scale = half_rate ? {cyc[19:0], 1'b0} : cyc;
        end
    endfunction

    function [20:0] rate_cyc;
        input [1:0] r;
        begin
            case (r)
                2'b00: rate_cyc = test_n ? RATE0_CYC : TRATE0_CYC;
                2'b01: rate_cyc = test_n ? RATE1_CYC : TRATE1_CYC;
                2'b10: rate_cyc = test_n ? RATE2_CYC : TRATE2_CYC;
                default: rate_cyc = test_n ? RATE3_CYC : TRATE3_CYC;
            endcase
        end
    endfunction

    wire [7:0] status = type1_reg ?
        {2'b00, head_up, seek_err_reg, crc_err_reg, ~track_zero_in, index_in, busy_out} :
        {4'h0, missing_reg, 2'b00, busy_out};

    always @(posedge clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_q_reg <= 8'h00;
            wdata_q_reg <= 8'h00;
            wstrb_q_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_q_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_q_reg <= s_axi_wdata[7:0];
                wstrb_q_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= map_w ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= map_r ? 2'b00 : 2'b10;
                case (s_axi_araddr)
                    `FHS_OFF_CMD_STAT: s_axi_rdata <= {24'h000000, status};
                    `FHS_OFF_TRACK: s_axi_rdata <= {24'h000000, track_reg};
                    `FHS_OFF_SECTOR: s_axi_rdata <= {24'h000000, sector_reg};
                    `FHS_OFF_DATA: s_axi_rdata <= {24'h000000, data_reg};
                    `FHS_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_reg};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // sequencer; bus writes to track/sector/data share this process since
    // the sequencer also updates track and sector
    always @(posedge clk) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            cmd_reg <= 8'h00;
            track_reg <= 8'h00;
            sector_reg <= 8'h00;
            data_reg <= 8'h00;
            ctrl_reg <= `FHS_CTRL_RESET;
            tmr_reg <= 21'h000000;
            steps_reg <= 8'h00;
            revs_reg <= 3'h0;
            idle_idx_reg <= 4'h0;
            index_prev_reg <= 1'b0;
            side_seen_reg <= 1'b0;
            crc_err_reg <= 1'b0;
            seek_err_reg <= 1'b0;
            missing_reg <= 1'b0;
            type1_reg <= 1'b1;
            step_out <= 1'b0;
            direction_out <= 1'b0;
            head_engage_out <= 1'b0;
            side_select_out <= 1'b0;
            sector_found_out <= 1'b0;
            command_done_irq <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            index_prev_reg <= index_in;
            sector_found_out <= 1'b0;
            // a completion in the same cycle below overrides this clear
            if (rd_stat || (wr_cmd && (!busy_out || is_force)))
                command_done_irq <= 1'b0;
            if (tmr_reg != 21'h000000)
                tmr_reg <= tmr_reg - 21'h000001;
            if (do_write && wstrb_q_reg) begin
                case (awaddr_q_reg)
                    `FHS_OFF_TRACK: track_reg <= wdata_q_reg;
                    `FHS_OFF_SECTOR: sector_reg <= wdata_q_reg;
                    `FHS_OFF_DATA: data_reg <= wdata_q_reg;
                    `FHS_OFF_CTRL: ctrl_reg <= wdata_q_reg;
                    default: ;
                endcase
            end
            if (!busy_out && index_edge) begin
                if (idle_idx_reg == `FHS_IDLE_INDEX - 4'h1) begin
                    head_engage_out <= 1'b0; // RQ10
                    idle_idx_reg <= 4'h0;
                end else begin
                    idle_idx_reg <= idle_idx_reg + 4'h1;
                end
            end
            if (busy_out)
                idle_idx_reg <= 4'h0;

            if (wr_cmd && is_force) begin
                // abort; a zero condition nibble ends without interrupt
                state_reg <= S_IDLE;
                busy_out <= 1'b0; // RQ21 RQ24
                step_out <= 1'b0;
                if (wdata_q_reg[3:0] != 4'h0)
                    command_done_irq <= 1'b1;
            end else if (wr_cmd && !busy_out) begin
                cmd_reg <= wdata_q_reg;
                busy_out <= 1'b1; // RQ19
                revs_reg <= 3'h0;
                steps_reg <= 8'h00;
                side_seen_reg <= 1'b0;
                crc_err_reg <= 1'b0;
                seek_err_reg <= 1'b0;
                missing_reg <= 1'b0;
                type1_reg <= ~wdata_q_reg[7];
                if (!wdata_q_reg[7]) begin
                    // positioning commands: side select untouched RQ18
                    if (wdata_q_reg[`FHS_CMD_HEAD])
                        head_engage_out <= 1'b1; // RQ9
                    else if (!wdata_q_reg[`FHS_CMD_VERIFY])
                        head_engage_out <= 1'b0; // RQ10
                    if (wdata_q_reg[6:5] == 2'b10)
                        direction_out <= 1'b1; // RQ2 RQ16
                    else if (wdata_q_reg[6:5] == 2'b11 || wdata_q_reg[6:4] == 3'b000)
                        direction_out <= 1'b0; // RQ2 RQ17
                    else if (wdata_q_reg[6:4] == 3'b001)
                        direction_out <= data_reg > track_reg; // RQ2 RQ14
                    if (wdata_q_reg[6:4] == 3'b000 && !track_zero_in) begin
                        track_reg <= 8'h00; // RQ12
                        state_reg <= S_GAP;
                        tmr_reg <= 21'h000000;
                    end else if (wdata_q_reg[6:4] == 3'b001 && data_reg == track_reg) begin
                        state_reg <= S_GAP;
                        tmr_reg <= 21'h000000;
                    end else begin
                        state_reg <= S_DIR;
                        tmr_reg <= DIR_SETUP; // RQ2
                    end
                end else if (wdata_q_reg[7:5] == 3'b100) begin
                    head_engage_out <= 1'b1; // RQ5 RQ9
                    if (ctrl_reg[`FHS_CTL_SIDE_VAR])
                        side_select_out <= wdata_q_reg[`FHS_CMD_SIDE_SEL];
                    state_reg <= wdata_q_reg[`FHS_CMD_E_DELAY] ? S_SETTLE : S_HEAD;
                    tmr_reg <= scale(SETTLE_CYC); // RQ5
                end else begin
                    // write sector, address and track commands live outside this block
                    busy_out <= 1'b0; // RQ24
                    command_done_irq <= 1'b1;
                end
            end else begin
                case (state_reg)
                    S_IDLE: ;
                    S_DIR: if (tmr_reg == 21'h000000) begin
                        step_out <= 1'b1;
                        state_reg <= S_PULSE;
                        // the pulse is high for the load cycle plus the count down
                        tmr_reg <= (ctrl_reg[`FHS_CTL_DENSITY] ? PULSE_SD : PULSE_DD) - 21'h000001; // RQ1
                        steps_reg <= steps_reg + 8'h01;
                        if (cmd_reg[6:4] == 3'b001 || (cmd_reg[6:5] != 2'b00 && cmd_t))
                            track_reg <= direction_out ? track_reg + 8'h01 : track_reg - 8'h01; // RQ14 RQ15 RQ23
                    end
                    S_PULSE: if (tmr_reg == 21'h000000) begin
                        step_out <= 1'b0;
                        state_reg <= S_GAP;
                        tmr_reg <= scale(rate_cyc(cmd_reg[1:0])); // RQ3
                    end
                    S_GAP: if (tmr_reg == 21'h000000) begin
                        if (cmd_reg[6:4] == 3'b000 && track_zero_in) begin
                            if (steps_reg == `FHS_RESTORE_MAX) begin
                                seek_err_reg <= cmd_v; // RQ13
                                state_reg <= S_IDLE;
                                busy_out <= 1'b0;
                                command_done_irq <= 1'b1;
                            end else begin
                                step_out <= 1'b1;
                                state_reg <= S_PULSE;
                                tmr_reg <= (ctrl_reg[`FHS_CTL_DENSITY] ? PULSE_SD : PULSE_DD) - 21'h000001; // RQ1
                                steps_reg <= steps_reg + 8'h01;
                            end
                        end else if (cmd_reg[6:4] == 3'b001 && data_reg != track_reg) begin
                            state_reg <= S_DIR;
                            tmr_reg <= 21'h000000;
                        end else begin
                            if (cmd_reg[6:4] == 3'b000)
                                track_reg <= 8'h00; // RQ12
                            if (cmd_v) begin
                                head_engage_out <= 1'b1; // RQ9
                                state_reg <= test_n ? S_SETTLE : S_HEAD; // RQ4
                                tmr_reg <= scale(SETTLE_CYC);
                            end else begin
                                state_reg <= S_IDLE;
                                busy_out <= 1'b0; // RQ24
                                command_done_irq <= 1'b1;
                            end
                        end
                    end
                    S_SETTLE: if (tmr_reg == 21'h000000)
                        state_reg <= S_HEAD; // RQ4 RQ5
                    S_HEAD: if (head_engaged_in) begin
                        state_reg <= S_SEARCH; // RQ5
                        revs_reg <= 3'h0;
                    end
                    S_SEARCH: begin
                        if (id_valid_in && head_up) begin // RQ11
                            if (type1_reg) begin
                                if (id_track_in == track_reg && id_crc_ok_in) begin
                                    state_reg <= S_IDLE; // RQ6
                                    busy_out <= 1'b0;
                                    command_done_irq <= 1'b1;
                                end else if (id_track_in == track_reg) begin
                                    crc_err_reg <= 1'b1; // RQ7
                                end
                            end else begin
                                if (side_ok)
                                    side_seen_reg <= 1'b1;
                                if (id_track_in == track_reg && id_sector_in == sector_reg && side_ok
                                        && id_crc_ok_in) begin
                                    sector_found_out <= 1'b1; // RQ19
                                    state_reg <= S_XFER;
                                end
                            end
                        end
                        if (index_edge && state_reg == S_SEARCH) begin
                            revs_reg <= revs_reg + 3'h1;
                            if (type1_reg && revs_reg == `FHS_VERIFY_REVS - 3'h1) begin
                                seek_err_reg <= 1'b1; // RQ8
                                state_reg <= S_IDLE;
                                busy_out <= 1'b0;
                                command_done_irq <= 1'b1;
                            end else if (!type1_reg && ((revs_reg == `FHS_SEARCH_REVS - 3'h1 && (side_seen_reg
                                    || !cmp_side)) || revs_reg == `FHS_SIDE_REVS - 3'h1)) begin
                                missing_reg <= 1'b1; // RQ20 RQ22
                                state_reg <= S_IDLE;
                                busy_out <= 1'b0;
                                command_done_irq <= 1'b1;
                            end
                        end
                    end
                    S_XFER: if (sector_done_in) begin
                        if (cmd_reg[`FHS_CMD_MULTI]) begin
                            sector_reg <= sector_reg + 8'h01; // RQ21
                            revs_reg <= 3'h0;
                            side_seen_reg <= 1'b0;
                            state_reg <= S_SEARCH;
                        end else begin
                            state_reg <= S_IDLE;
                            busy_out <= 1'b0; // RQ24
                            command_done_irq <= 1'b1;
                        end
                    end
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end

endmodule // fhs_seek_search

`default_nettype wire

/* tb/fhs_props.sv */
// fhs_props.sv: drive-side checks.
// Sees only sequencer ports; bound below.
`include "fhs_defines.vh"
`default_nettype none
module fhs_props (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // drive and completion
    input wire logic step_out,
    input wire logic direction_out,
    input wire logic head_engage_out,
    input wire logic head_engaged_in,
    input wire logic sector_found_out,
    input wire logic command_done_irq,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hi_cnt;
    logic [9:0] dir_age;
    logic dir_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // counters: too long for a repetition
    always @(posedge clk) begin
        dir_q <= direction_out;
        hi_cnt <= (!nrst || !step_out) ? 8'h00 : hi_cnt + 8'h01;
        if (!nrst || direction_out != dir_q) dir_age <= 10'h000;
        else if (dir_age != 10'h3FF) dir_age <= dir_age + 10'h001;
    end
    property p_pulse_width; $fell(step_out) |-> hi_cnt inside {`FHS_PULSE_DD_CYC, `FHS_PULSE_SD_CYC}; endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse width");
    property p_dir_setup; $rose(step_out) |-> dir_age >= `FHS_DIR_SETUP_CYC - 4; endproperty
    a_dir_setup: assert property (p_dir_setup) else $error("dir setup");
    property p_dir_hold; step_out |-> $stable(direction_out); endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("dir hold");
    property p_gap; $fell(step_out) |=> !step_out [*8]; endproperty
    a_gap: assert property (p_gap) else $error("step gap");
    property p_busy_irq; $fell(busy_out) |-> $rose(command_done_irq); endproperty
    a_busy_irq: assert property (p_busy_irq) else $error("busy without irq");
    property p_irq_busy; $rose(command_done_irq) |-> !busy_out; endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("irq while busy");
    property p_media; sector_found_out |-> head_engage_out && head_engaged_in; endproperty
    a_media: assert property (p_media) else $error("head not engaged");
    property p_found; sector_found_out |-> busy_out ##1 !sector_found_out; endproperty
    a_found: assert property (p_found) else $error("found outside command");
    property p_step_busy; step_out |-> busy_out; endproperty
    a_step_busy: assert property (p_step_busy) else $error("step while idle");
endmodule // fhs_props
bind fhs_seek_search fhs_props u_fhs_props (.*);
`default_nettype wire

/* tb/fhs_drive_model.sv */
// fhs_drive_model.sv: drive, head one-shot, id reader.
// Assumes 400-clock turns, sectors 1 to 8.
`default_nettype none
module fhs_drive_model (
    // from the sequencer, plus the clock and the testbench's bad_crc control
    input wire logic clk,
    input wire logic step_out,
    input wire logic direction_out,
    input wire logic head_engage_out,
    input wire logic sector_found_out,
    input wire logic bad_crc,
    // drive status and id fields
    output logic head_engaged_in,
    output logic track_zero_in,
    output logic index_in,
    output logic id_valid_in,
    output logic [7:0] id_track_in,
    output logic id_side_in,
    output logic [7:0] id_sector_in,
    output logic id_crc_ok_in,
    output logic sector_done_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int t = 0, pos = 3, eng = 0, dn = 0;
    logic step_q = 0;
    always @(posedge clk) begin
        t <= (t == 399) ? 0 : t + 1;
        step_q <= step_out;
        if (step_out && !step_q) pos <= direction_out ? pos + 1 : (pos > 0 ? pos - 1 : 0);
        eng <= head_engage_out ? eng + (eng < 20) : 0;
        dn <= sector_found_out ? 30 : (dn > 0 ? dn - 1 : 0);
    end
    // track, sector and crc lines idle inverted so stale values differ
    assign head_engaged_in = (eng == 20);
    assign track_zero_in = (pos != 0);
    assign index_in = (t < 4);
    assign id_valid_in = (t % 40 == 20) && (t >= 40) && (t < 360);
    assign id_track_in = id_valid_in ? 8'(pos) : ~8'(pos);
    assign id_sector_in = id_valid_in ? 8'(t / 40) : ~8'(t / 40);
    assign id_side_in = id_valid_in ? 1'b0 : 1'(t);
    assign id_crc_ok_in = id_valid_in ? !bad_crc : bad_crc;
    assign sector_done_in = (dn == 1);
endmodule // fhs_drive_model
`default_nettype wire

/* tb/testbench.sv */
// testbench.sv: register scenarios for the sequencer.
// Assumes the model starts on track 3; short rates.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, step_out, direction_out, head_engage_out;
    logic side_select_out, head_engaged_in, track_zero_in, index_in, id_valid_in, id_side_in, id_crc_ok_in;
    logic sector_found_out, sector_done_in, command_done_irq, busy_out, bad_crc;
    logic [7:0] s_axi_awaddr, s_axi_araddr, id_track_in, id_sector_in, rd;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int n_fail = 0, checked = 0, n_found = 0;
    fhs_seek_search #(.RATE0_CYC(40), .RATE1_CYC(60), .RATE2_CYC(80), .RATE3_CYC(100),
        .SETTLE_CYC(50)) u_fhs_seek_search (.*);
    fhs_drive_model u_fhs_drive_model (.*);
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (sector_found_out === 1'b1) n_found++;
    task chk(string w, logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task wr(logic [7:0] a, d, logic [3:0] s = 4'h1);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task rd_reg(logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task run(logic [7:0] c, m, e);
        wr(8'h00, c);
        repeat (6000) if (command_done_irq !== 1'b1) @(posedge clk);
        chk("busy", {7'h0, busy_out}, 8'h00);
        rd_reg(8'h00);
        chk("status", rd & m, e);
    endtask
    task s_restore;
        rd_reg(8'h14);
        chk("resp", {6'h0, rsp}, 8'h02);
        run(8'h00, 8'h3D, 8'h04);
        rd_reg(8'h04);
        chk("track", rd, 8'h00);
    endtask
    task s_seek;
        wr(8'h0C, 8'h05);
        run(8'h15, 8'h3D, 8'h20);
        rd_reg(8'h04);
        chk("track", rd, 8'h05);
        wr(8'h0C, 8'hAA, 4'h0);
        rd_reg(8'h0C);
        chk("data", rd, 8'h05);
    endtask
    task s_sector;
        wr(8'h08, 8'h03);
        run(8'h84, 8'h09, 8'h00);
        chk("found", 8'(n_found), 8'h01);
        wr(8'h08, 8'h07);
        run(8'h90, 8'h09, 8'h08);
        rd_reg(8'h08);
        chk("sector", rd, 8'h09);
        chk("found", 8'(n_found), 8'h03);
    endtask
    task s_verify_fail;
        run(8'h46, 8'h18, 8'h10);
        rd_reg(8'h04);
        chk("track", rd, 8'h05);
        bad_crc <= 1;
        run(8'h67, 8'h18, 8'h18);
        bad_crc <= 0;
    endtask
    task s_step;
        wr(8'h10, 8'h03);
        run(8'h30, 8'h3D, 8'h00);
        chk("engage", {7'h0, head_engage_out}, 8'h00);
        rd_reg(8'h04);
        chk("track", rd, 8'h04);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {nrst, bad_crc, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (12) @(posedge clk);
        nrst <= 1;
        s_restore;
        s_seek;
        s_sector;
        s_verify_fail;
        s_step;
        give_verdict;
    end
    // about 10000 clocks needed
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
